// >>> pct_pkg.sv
// Purpose: Shared constants for the pointer color tagging unit
// Assumes: 32-bit core, single system clock, 8-bit register port address
// Notes:   Offsets are byte addresses on the plain register port

package pct_pkg;

  // ----------------------------------------------------------------
  // Register port geometry
  // ----------------------------------------------------------------
  localparam int unsigned PCT_REG_AW = 8;   // Register address width
  localparam int unsigned PCT_DW = 32;      // Register data width

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PCT_CFG_OFF = 8'h00;    // Security configuration word
  localparam logic [7:0] PCT_COLOR_OFF = 8'h04;  // Last color handed out
  localparam logic [7:0] PCT_TCNT_OFF = 8'h08;   // Tagged data access count
  localparam logic [7:0] PCT_GEOM_OFF = 8'h0c;   // Color width and indicator position
  localparam logic [7:0] PCT_SEED_OFF = 8'h10;   // Color source reseed

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned PCT_EN_BIT = 0;          // tagging_enable_field position
  localparam logic PCT_EN_RST = 1'b1;              // Feature on after reset
  localparam int unsigned PCT_GEOM_SEL_LSB = 8;    // Indicator position field in GEOM
  localparam int unsigned PCT_GEOM_LW_LSB = 16;    // Region address width field in GEOM
  localparam logic [31:0] PCT_TCNT_RST = 32'h0000_0000;
  localparam logic [31:0] PCT_SEED_RST = 32'h0000_0001;  // Any nonzero LFSR start
  localparam logic [31:0] PCT_LFSR_TAPS = 32'h8020_0003; // Maximal-length taps

  // ----------------------------------------------------------------
  // Instruction encoding (custom opcode space)
  // ----------------------------------------------------------------
  localparam logic [6:0] PCT_OPC = 7'h0b;      // Custom-0 major opcode
  localparam logic [2:0] PCT_F3_TAG = 3'h0;    // Tag pointer
  localparam logic [2:0] PCT_F3_UNTAG = 3'h1;  // Untag pointer
  localparam logic [6:0] PCT_F7_ZERO = 7'h00;  // Upper function bits must be zero

  // ----------------------------------------------------------------
  // Pipeline latency of both paths
  // ----------------------------------------------------------------
  localparam int unsigned PCT_LAT_CYC = 1;     // Result one edge after request

  // Decoded operation
  typedef enum logic [2:0] {
    PCT_OP_NONE = 3'b001,
    PCT_OP_TAG = 3'b010,
    PCT_OP_UNTAG = 3'b100
  } pct_op_e;

endpackage

// >>> pct_color_source.sv
// Purpose: Free-running Galois LFSR that supplies pointer colors
// Assumes: Advanced every clock, reseed on request
// Notes:   Suits fault-only and logical attackers, not advanced ones

`timescale 1ns/1ns

module pct_color_source
  import pct_pkg::*;
#(
  parameter int unsigned W = 32,
  parameter logic [W-1:0] TAPS = PCT_LFSR_TAPS[W-1:0],
  parameter logic [W-1:0] SEED = PCT_SEED_RST[W-1:0]
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Reseed request
  input wire logic load_i,
  input wire logic [W-1:0] seed_i,
  // Current state
  output logic [W-1:0] state_o
);

  logic [W-1:0] state_reg;   // LFSR state
  logic [W-1:0] state_next;  // One step ahead

  // ----------------------------------------------------------------
  // Step logic
  // ----------------------------------------------------------------
  // Galois step; zero seed refused since it locks the register
  always_comb begin
    state_next = {1'b0, state_reg[W-1:1]} ^ (state_reg[0] ? TAPS : '0);
    if (load_i && (seed_i != '0)) begin
      state_next = seed_i;
    end
  end

  // Clocked on every rising edge so the draw time is hard to predict
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= SEED;
    end else begin
      state_reg <= state_next;
    end
  end

  assign state_o = state_reg;

endmodule

// >>> pct_color_split.sv
// Purpose: Split a pointer into indicator, color and region address
// Assumes: Indicator bit sits above the color, color above the region bits
// Notes:   Purely combinational; used by both the ALU and the data path

`timescale 1ns/1ns

module pct_color_split #(
  parameter int unsigned AW = 32,
  parameter int unsigned CW = 8,
  parameter int unsigned SEL = 31,
  parameter logic [AW-1:0] OFFSET = '0
) (
  // Control
  input wire logic en_i,
  // Incoming pointer
  input wire logic [AW-1:0] addr_i,
  // Split result
  output logic tagged_o,
  output logic [CW-1:0] color_o,
  output logic [AW-1:0] addr_o
);

  localparam int unsigned LW = SEL - CW;  // Region address width

  logic [AW-1:0] low_ext;  // Region bits, zero extended

  // ----------------------------------------------------------------
  // Split
  // ----------------------------------------------------------------
  always_comb begin
    low_ext = '0;
    low_ext[LW-1:0] = addr_i[LW-1:0];
    tagged_o = en_i && addr_i[SEL];
    if (tagged_o) begin
      color_o = addr_i[SEL-1 -: CW];
      addr_o = low_ext + OFFSET;
    end else begin
      // Untagged or disabled: untouched, color zero
      color_o = '0;
      addr_o = addr_i;
    end
  end

endmodule

// >>> pct_tagging_unit.sv
// Purpose: Pointer tag/untag execution and data tweak color extraction
// Assumes: Core presents one decoded word per cycle; bus requests are flopped
// Notes:   Both result paths answer one edge after their request

`timescale 1ns/1ns

module pct_tagging_unit
  import pct_pkg::*;
#(
  parameter int unsigned AW = 32,
  parameter int unsigned CW = 8,
  parameter int unsigned SEL = AW - 1,
  parameter logic [AW-1:0] OFFSET = '0,
  parameter int unsigned RNG_W = 32
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [PCT_REG_AW-1:0] reg_addr_i,
  input wire logic [PCT_DW-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [PCT_DW-1:0] reg_rdata_o,
  // Instruction issue from decode
  input wire logic ins_valid_i,
  input wire logic [31:0] ins_word_i,
  input wire logic [AW-1:0] ins_rs1_i,
  // Instruction result to writeback
  output logic res_valid_o,
  output logic [4:0] res_rd_o,
  output logic [AW-1:0] res_data_o,
  // Data bus request from the load/store unit
  input wire logic dreq_i,
  input wire logic dreq_we_i,
  input wire logic [AW-1:0] dreq_addr_i,
  input wire logic [31:0] dreq_wdata_i,
  // Request toward the data encryption engine
  output logic eng_req_o,
  output logic eng_we_o,
  output logic [AW-1:0] eng_addr_o,
  output logic [31:0] eng_wdata_o,
  output logic eng_tagged_o,
  output logic [CW-1:0] eng_color_o
);

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  // Protected region spans 2**LW bytes; more color means less region
  localparam int unsigned LW = SEL - CW;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic en_reg;                       // tagging_enable_field
  logic [CW-1:0] color_last_reg;      // Last color handed to a tag
  logic [31:0] tcnt_reg;              // Tagged data accesses seen
  logic [31:0] tcnt_next;             // Counter step
  logic [PCT_DW-1:0] rdata_reg;       // Read data, one cycle later
  logic [PCT_DW-1:0] rdata_next;      // Read mux
  logic res_valid_reg;                // Result strobe
  logic [4:0] res_rd_reg;             // Destination register
  logic [AW-1:0] res_data_reg;        // Tagged or plain pointer
  logic [AW-1:0] res_data_next;       // ALU output
  logic eng_req_reg;                  // Engine request strobe
  logic eng_we_reg;                   // Engine write flag
  logic [AW-1:0] eng_addr_reg;        // Remapped address
  logic [31:0] eng_wdata_reg;         // Write data passed through
  logic eng_tagged_reg;               // Tagged access flag
  logic [CW-1:0] eng_color_reg;       // Color part of the tweak
  pct_op_e op;                        // Decoded operation
  logic [RNG_W-1:0] rng_state;        // color_random_source state
  logic rng_load;                     // Reseed write
  logic [CW-1:0] color_new;           // Fresh color for a tag
  logic [AW-1:0] rel_addr;            // Pointer relative to region base
  logic un_tagged;                    // Untag path: operand carries a color
  logic [AW-1:0] un_addr;             // Untag path: plain pointer
  logic d_tagged;                     // Data path: access is tagged
  logic [CW-1:0] d_color;             // Data path: extracted color
  logic [AW-1:0] d_addr;              // Data path: engine address
  logic wr_cfg;                       // Write hits config
  logic [PCT_DW-1:0] geom_word;       // Read-only geometry word

  // ----------------------------------------------------------------
  // Color source
  // ----------------------------------------------------------------
  // Entropy must cover every color bit
  if (RNG_W < CW) begin : g_rng_too_small
    $error("Color source narrower than the color field");
  end

  // Free-running LFSR: enough against fault and logical attackers;
  // swap in a cryptographic generator for stronger threat models
  pct_color_source #(
    .W(RNG_W),
    .TAPS(PCT_LFSR_TAPS[RNG_W-1:0]),
    .SEED(PCT_SEED_RST[RNG_W-1:0])
  ) u_rng (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .load_i(rng_load),
    .seed_i(reg_wdata_i[RNG_W-1:0]),
    .state_o(rng_state)
  );

  // Low bits of the source become the color
  assign color_new = rng_state[CW-1:0];

  // ----------------------------------------------------------------
  // Shared pointer split units
  // ----------------------------------------------------------------
  // One parameter set feeds both instances so the layouts never drift
  pct_color_split #(
    .AW(AW),
    .CW(CW),
    .SEL(SEL),
    .OFFSET(OFFSET)
  ) u_split_alu (
    .en_i(1'b1),
    .addr_i(ins_rs1_i),
    .tagged_o(un_tagged),
    .color_o(),
    .addr_o(un_addr)
  );

  // Data side honours the enable; the untag side always strips
  pct_color_split #(
    .AW(AW),
    .CW(CW),
    .SEL(SEL),
    .OFFSET(OFFSET)
  ) u_split_data (
    .en_i(en_reg),
    .addr_i(dreq_addr_i),
    .tagged_o(d_tagged),
    .color_o(d_color),
    .addr_o(d_addr)
  );

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  // Only exact encodings are claimed; anything else is left to the core
  always_comb begin
    op = PCT_OP_NONE;
    if (ins_valid_i && (ins_word_i[6:0] == PCT_OPC) &&
        (ins_word_i[31:25] == PCT_F7_ZERO)) begin
      case (ins_word_i[14:12])
        PCT_F3_TAG: begin
          op = PCT_OP_TAG;
        end
        PCT_F3_UNTAG: begin
          op = PCT_OP_UNTAG;
        end
        default: begin
          op = PCT_OP_NONE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // ALU: tag and untag
  // ----------------------------------------------------------------
  // Region-relative address keeps tag and data remap inverse of each other
  assign rel_addr = ins_rs1_i - OFFSET;

  always_comb begin
    res_data_next = ins_rs1_i;
    case (op)
      PCT_OP_TAG: begin
        if (en_reg) begin
          // Indicator, fresh color, region bits above offset
          res_data_next = '0;
          res_data_next[SEL] = 1'b1;
          res_data_next[SEL-1 -: CW] = color_new;
          res_data_next[LW-1:0] = rel_addr[LW-1:0];
        end else begin
          // Feature off: pointer comes back untouched
          res_data_next = ins_rs1_i;
        end
      end
      PCT_OP_UNTAG: begin
        // Plain pointer; an untagged operand passes unchanged
        res_data_next = un_tagged ? un_addr : ins_rs1_i;
      end
      PCT_OP_NONE: begin
        res_data_next = ins_rs1_i;
      end
      default: begin
        res_data_next = ins_rs1_i;
      end
    endcase
  end

  // Result strobe, one edge after issue
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res_valid_reg <= 1'b0;
      res_rd_reg <= 5'h00;
      res_data_reg <= '0;
    end else begin
      res_valid_reg <= (op != PCT_OP_NONE);
      res_rd_reg <= ins_word_i[11:7];
      res_data_reg <= res_data_next;
    end
  end

  // Remember the color handed out, for software inspection
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      color_last_reg <= '0;
    end else if ((op == PCT_OP_TAG) && en_reg) begin
      color_last_reg <= color_new;
    end
  end

  // ----------------------------------------------------------------
  // Data tweak path
  // ----------------------------------------------------------------
  // Whole request is flopped so address, color and strobe stay aligned
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      eng_req_reg <= 1'b0;
      eng_we_reg <= 1'b0;
      eng_addr_reg <= '0;
      eng_wdata_reg <= 32'h0000_0000;
      eng_tagged_reg <= 1'b0;
      eng_color_reg <= '0;
    end else begin
      eng_req_reg <= dreq_i;
      eng_we_reg <= dreq_we_i;
      eng_addr_reg <= d_addr;
      eng_wdata_reg <= dreq_wdata_i;
      // No request, no color: idle tweak stays at zero
      eng_tagged_reg <= dreq_i && d_tagged;
      eng_color_reg <= dreq_i ? d_color : '0;
    end
  end

  // Tagged access counter, wraps silently
  always_comb begin
    tcnt_next = tcnt_reg;
    if (dreq_i && d_tagged) begin
      tcnt_next = tcnt_reg + 32'h0000_0001;
    end
    if (reg_we_i && (reg_addr_i == PCT_TCNT_OFF)) begin
      // Any write clears; a hit in the same cycle still counts
      tcnt_next = (dreq_i && d_tagged) ? 32'h0000_0001 : PCT_TCNT_RST;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tcnt_reg <= PCT_TCNT_RST;
    end else begin
      tcnt_reg <= tcnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  assign wr_cfg = reg_we_i && (reg_addr_i == PCT_CFG_OFF);
  assign rng_load = reg_we_i && (reg_addr_i == PCT_SEED_OFF);

  // Enable field; takes effect on the next request after the write
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_reg <= PCT_EN_RST;
    end else if (wr_cfg) begin
      en_reg <= reg_wdata_i[PCT_EN_BIT];
    end
  end

  // Geometry word lets software locate the indicator and region size
  always_comb begin
    geom_word = '0;
    geom_word[7:0] = 8'(CW);
    geom_word[PCT_GEOM_SEL_LSB +: 8] = 8'(SEL);
    geom_word[PCT_GEOM_LW_LSB +: 8] = 8'(LW);
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rdata_next = '0;
    case (reg_addr_i)
      PCT_CFG_OFF: begin
        rdata_next[PCT_EN_BIT] = en_reg;
      end
      PCT_COLOR_OFF: begin
        rdata_next[CW-1:0] = color_last_reg;
      end
      PCT_TCNT_OFF: begin
        rdata_next = tcnt_reg;
      end
      PCT_GEOM_OFF: begin
        rdata_next = geom_word;
      end
      PCT_SEED_OFF: begin
        // Reading the live state would leak the next colors
        rdata_next = '0;
      end
      default: begin
        rdata_next = '0;
      end
    endcase
  end

  // Data valid only in the cycle after the read strobe
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= '0;
    end else if (reg_re_i) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops on the one system clock
  // ----------------------------------------------------------------
  assign reg_rdata_o = rdata_reg;
  assign res_valid_o = res_valid_reg;
  assign res_rd_o = res_rd_reg;
  assign res_data_o = res_data_reg;
  assign eng_req_o = eng_req_reg;
  assign eng_we_o = eng_we_reg;
  assign eng_addr_o = eng_addr_reg;
  assign eng_wdata_o = eng_wdata_reg;
  assign eng_tagged_o = eng_tagged_reg;
  assign eng_color_o = eng_color_reg;

endmodule

// >>> pct_tagging_unit_properties.sv
// Purpose: Port-level properties for the pointer color tagging unit
// Assumes: One clock, async active-low reset
// Notes:   Enable is internal; tag accepts either outcome

`timescale 1ns/1ns

module pct_tagging_unit_checker
  import pct_pkg::*;
#(
  parameter int unsigned AW = 32,
  parameter int unsigned CW = 8,
  parameter int unsigned SEL = AW - 1,
  parameter logic [AW-1:0] OFFSET = '0
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [PCT_REG_AW-1:0] reg_addr_i,
  input wire logic reg_re_i,
  input wire logic [PCT_DW-1:0] reg_rdata_o,
  // Instruction side
  input wire logic ins_valid_i,
  input wire logic [31:0] ins_word_i,
  input wire logic [AW-1:0] ins_rs1_i,
  input wire logic res_valid_o,
  input wire logic [4:0] res_rd_o,
  input wire logic [AW-1:0] res_data_o,
  // Data side
  input wire logic dreq_i,
  input wire logic dreq_we_i,
  input wire logic [AW-1:0] dreq_addr_i,
  input wire logic [31:0] dreq_wdata_i,
  input wire logic eng_req_o,
  input wire logic eng_we_o,
  input wire logic [AW-1:0] eng_addr_o,
  input wire logic [31:0] eng_wdata_o,
  input wire logic eng_tagged_o,
  input wire logic [CW-1:0] eng_color_o
);
  // ----------------------------------------------------------------
  // Helper decode
  // ----------------------------------------------------------------
  localparam int unsigned LW = SEL - CW;  // Region address width
  localparam logic [31:0] GEOM = {8'h00, 8'(LW), 8'(SEL), 8'(CW)};
  logic legal_op;  // Custom opcode with zero upper bits
  logic tag_go;  // Tag issued this cycle
  logic untag_go;  // Untag issued this cycle
  logic [AW-1:0] untag_exp;  // Plain pointer from a tagged one
  logic [AW-1:0] tag_low;  // Pointer shifted into region space
  logic [AW-1:0] remap_exp;  // Engine address for a tagged access
  assign legal_op = ins_valid_i && ins_word_i[6:0] == PCT_OPC && ins_word_i[31:25] == PCT_F7_ZERO;
  assign tag_go = legal_op && ins_word_i[14:12] == PCT_F3_TAG;
  assign untag_go = legal_op && ins_word_i[14:12] == PCT_F3_UNTAG;
  assign untag_exp = {{(AW-LW){1'b0}}, ins_rs1_i[LW-1:0]} + OFFSET;
  assign tag_low = ins_rs1_i - OFFSET;
  assign remap_exp = {{(AW-LW){1'b0}}, dreq_addr_i[LW-1:0]} + OFFSET;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------
  // Instruction path
  // ----------------------------------------------------------------
  a_issue_answers: assert property ((tag_go || untag_go) |=>
    res_valid_o && res_rd_o == $past(ins_word_i[11:7])) else $error("no answer");
  a_other_refused: assert property (!(tag_go || untag_go) |=> !res_valid_o)
    else $error("stray result");
  // Tag off returns rs1, else indicator and region bits
  a_tag_shape: assert property (tag_go |=> res_data_o == $past(ins_rs1_i) ||
    (res_data_o[SEL] && res_data_o[LW-1:0] == $past(tag_low[LW-1:0])))
    else $error("tag malformed");
  a_untag_strip: assert property (untag_go && ins_rs1_i[SEL] |=>
    res_data_o == $past(untag_exp)) else $error("untag wrong");
  a_untag_pass: assert property (untag_go && !ins_rs1_i[SEL] |=>
    res_data_o == $past(ins_rs1_i)) else $error("untag altered plain");

  // ----------------------------------------------------------------
  // Data tweak path
  // ----------------------------------------------------------------
  a_eng_follows: assert property (dreq_i |=> eng_req_o &&
    eng_we_o == $past(dreq_we_i) && eng_wdata_o == $past(dreq_wdata_i))
    else $error("request not forwarded");
  a_no_req_idle: assert property (!dreq_i |=> !eng_req_o && !eng_tagged_o)
    else $error("stray engine request");
  a_plain_passes: assert property (dreq_i && !dreq_addr_i[SEL] |=>
    !eng_tagged_o && eng_color_o == '0 && eng_addr_o == $past(dreq_addr_i))
    else $error("plain access changed");
  a_tagged_remap: assert property (eng_tagged_o |-> eng_addr_o == $past(remap_exp) &&
    eng_color_o == $past(dreq_addr_i[SEL-1:LW])) else $error("remap wrong");
  a_color_zeroed: assert property (!eng_tagged_o |-> eng_color_o == '0)
    else $error("color leak");

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  a_geom_read: assert property (reg_re_i && reg_addr_i == PCT_GEOM_OFF |=>
    reg_rdata_o == GEOM) else $error("geom wrong");
  a_rdata_quiet: assert property (!reg_re_i |=> reg_rdata_o == '0)
    else $error("stray read data");
endmodule

bind pct_tagging_unit pct_tagging_unit_checker #(.AW(AW), .CW(CW), .SEL(SEL), .OFFSET(OFFSET))
  u_checker (.*);

// >>> pct_engine_model.sv
// Purpose: Behavioural data encryption engine front end
// Assumes: Engine never stalls; one request per cycle at most
// Notes:   Holds last write and its tweak

`timescale 1ns/1ns

module pct_engine_model #(
  parameter int unsigned AW = 32,
  parameter int unsigned CW = 8
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Request from the tagging unit
  input wire logic eng_req_i,
  input wire logic eng_we_i,
  input wire logic [AW-1:0] eng_addr_i,
  input wire logic [31:0] eng_wdata_i,
  input wire logic eng_tagged_i,
  input wire logic [CW-1:0] eng_color_i,
  // Last write request seen
  output logic [AW-1:0] last_addr_o,
  output logic [31:0] last_wdata_o,
  output logic last_tagged_o,
  output logic [CW-1:0] last_color_o
);
  // ----------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------
  // Writes only; bit SEL is the integrator's, left unused
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_addr_o <= '0;
      last_wdata_o <= '0;
      last_tagged_o <= 1'b0;
      last_color_o <= '0;
    end else if (eng_req_i && eng_we_i) begin
      last_addr_o <= eng_addr_i;
      last_wdata_o <= eng_wdata_i;
      last_tagged_o <= eng_tagged_i;
      last_color_o <= eng_color_i;
    end
  end
endmodule

// >>> pct_testbench.sv
// Purpose: Directed test of tag, untag, data remap and registers
// Assumes: Region offset overridden to a nonzero value
// Notes:   Colors checked against the color register

`timescale 1ns/1ns

`define CHECK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("unexpected %s: expected %h seen %h", nm, exp, got); end end

module testbench;
  import pct_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [31:0] OFF = 32'h0040_0000;  // Protected region base
  localparam logic [31:0] PLAIN = 32'h0052_3456;  // Pointer inside the region
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic ins_valid_i = 1'b0;
  logic [31:0] ins_word_i = 32'h0;
  logic [31:0] ins_rs1_i = 32'h0;
  logic res_valid_o, dreq_i = 1'b0, dreq_we_i = 1'b0;
  logic [4:0] res_rd_o;
  logic [31:0] res_data_o, dreq_addr_i = 32'h0, dreq_wdata_i = 32'h0;
  logic eng_req_o, eng_we_o, eng_tagged_o, m_tag;
  logic [31:0] eng_addr_o, eng_wdata_o, m_addr, m_wdata, res, t1, t2;
  logic [7:0] eng_color_o, m_color;
  logic vld;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;

  always #4 mclk_i = ~mclk_i;

  pct_tagging_unit #(.OFFSET(OFF)) uut (.*);

  pct_engine_model u_engine (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .eng_req_i(eng_req_o),
    .eng_we_i(eng_we_o), .eng_addr_i(eng_addr_o), .eng_wdata_i(eng_wdata_o),
    .eng_tagged_i(eng_tagged_o), .eng_color_i(eng_color_o), .last_addr_o(m_addr),
    .last_wdata_o(m_wdata), .last_tagged_o(m_tag), .last_color_o(m_color));

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_we_i <= 1'b0;
  endtask

  // Read data stands one cycle
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_re_i <= 1'b0;
    #1;
    `CHECK(nm, exp, reg_rdata_o)
  endtask

  // One instruction, result next edge
  task automatic issue(input logic [2:0] f3, input logic [6:0] f7, input logic [31:0] p);
    @(posedge mclk_i);
    ins_valid_i <= 1'b1;
    ins_word_i <= {f7, 5'd0, 5'd1, f3, 5'd9, PCT_OPC};
    ins_rs1_i <= p;
    @(posedge mclk_i);
    ins_valid_i <= 1'b0;
    #1;
    vld = res_valid_o;
    res = res_data_o;
    `CHECK("res_rd", 5'd9, res_rd_o)
  endtask

  // Store, then read the engine record
  task automatic access(input logic [31:0] a, input logic [31:0] ea, input logic [7:0] ec,
                        input logic et);
    @(posedge mclk_i);
    dreq_i <= 1'b1;
    dreq_we_i <= 1'b1;
    dreq_addr_i <= a;
    dreq_wdata_i <= ~a;
    @(posedge mclk_i);
    dreq_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    `CHECK("eng_addr", ea, m_addr)
    `CHECK("eng_color", ec, m_color)
    `CHECK("eng_tagged", et, m_tag)
    `CHECK("eng_wdata", ~a, m_wdata)
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      $display("timeout");
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    rchk("cfg", PCT_CFG_OFF, 32'h1);
    rchk("tcnt", PCT_TCNT_OFF, 32'h0);
    rchk("geom", PCT_GEOM_OFF, 32'h0017_1f08);
    rchk("seed", PCT_SEED_OFF, 32'h0);
    rchk("unmapped", 8'h14, 32'h0);
    $display("test registers done");
    issue(PCT_F3_TAG, PCT_F7_ZERO, PLAIN);
    t1 = res;
    `CHECK("tag_valid", 1'b1, vld)
    `CHECK("tag_bit", 1'b1, t1[31])
    `CHECK("tag_low", 23'h12_3456, t1[22:0])
    rchk("color", PCT_COLOR_OFF, {24'h0, t1[30:23]});
    issue(PCT_F3_TAG, PCT_F7_ZERO, PLAIN);
    t2 = res;
    rchk("color2", PCT_COLOR_OFF, {24'h0, t2[30:23]});
    issue(PCT_F3_UNTAG, PCT_F7_ZERO, t1);
    `CHECK("untag", PLAIN, res)
    issue(PCT_F3_UNTAG, PCT_F7_ZERO, PLAIN);
    `CHECK("untag_plain", PLAIN, res)
    access(t1, PLAIN, t1[30:23], 1'b1);
    access(PLAIN, PLAIN, 8'h00, 1'b0);
    rchk("tcnt1", PCT_TCNT_OFF, 32'h1);
    $display("test tag and remap done");
    issue(PCT_F3_TAG, 7'h01, PLAIN);
    `CHECK("bad_f7", 1'b0, vld)
    issue(3'h2, PCT_F7_ZERO, PLAIN);
    `CHECK("bad_f3", 1'b0, vld)
    $display("test refused encodings done");
    reg_wr(PCT_CFG_OFF, 32'h0);
    rchk("cfg_off", PCT_CFG_OFF, 32'h0);
    issue(PCT_F3_TAG, PCT_F7_ZERO, PLAIN);
    `CHECK("tag_off", PLAIN, res)
    issue(PCT_F3_UNTAG, PCT_F7_ZERO, t1);
    `CHECK("untag_off", PLAIN, res)
    access(t1, t1, 8'h00, 1'b0);
    rchk("tcnt_off", PCT_TCNT_OFF, 32'h1);
    $display("test disabled done");
    reg_wr(PCT_CFG_OFF, 32'h1);
    access(t2, PLAIN, t2[30:23], 1'b1);
    rchk("tcnt2", PCT_TCNT_OFF, 32'h2);
    reg_wr(PCT_TCNT_OFF, 32'h0);
    rchk("tcnt_clr", PCT_TCNT_OFF, 32'h0);
    reg_wr(PCT_SEED_OFF, 32'h0000_1234);
    rchk("seed_wo", PCT_SEED_OFF, 32'h0);
    $display("test counter done");
    give_verdict();
  end
endmodule
